// >>> include/vop_pkg.sv
// Package: register map, field positions, reset values and codes for the channel override block
package vop_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CAP_COUNT   = 8'h08;
	localparam logic [7:0] REG_OVERRIDE    = 8'h09;
	localparam logic [7:0] REG_PAT_CLK_EN  = 8'h0d;
	localparam logic [7:0] REG_SIG_DETECT  = 8'h14;
	localparam logic [7:0] REG_DIV_SELECT  = 8'h18;
	localparam logic [7:0] REG_CHARGE_PUMP = 8'h1b;
	localparam logic [7:0] REG_OUT_SELECT  = 8'h1e;
	localparam logic [7:0] REG_LOOP_DAC    = 8'h1f;
	localparam logic [7:0] REG_PAT_CONFIG  = 8'h30;
	// Controller command and status registers
	localparam logic [7:0] CMD_RATE        = 8'h40;
	localparam logic [7:0] CMD_STATUS      = 8'h41;
	localparam logic [7:0] CMD_PAT_LOW     = 8'h42;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int OVR_CAP_BIT      = 7;
	localparam int OVR_LOOP_DAC_BIT = 6;
	localparam int OVR_MUX_BIT      = 5;
	localparam int OVR_QCLK_BIT     = 4;
	localparam int OVR_CP_BIT       = 3;
	localparam int OVR_DIV_BIT      = 2;
	localparam int PAT_CLK_EN_BIT   = 5;
	localparam int SD_FORCE_ON_BIT  = 7;
	localparam int SD_FORCE_OFF_BIT = 6;
	localparam int DIV_LSB          = 4;
	localparam int MUX_LSB          = 5;
	localparam int PAT_EN_BIT       = 4;
	localparam int PAT_LOAD_BIT     = 3;

	// ----------------------------------------
	// Reset values and codes
	// ----------------------------------------
	localparam logic [7:0] OVR_RESET      = 8'h00;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] OUT_SEL_RESET  = 8'he0;
	localparam logic [7:0] CP_RESET       = 8'h03;
	localparam logic [2:0] DIV_MAX_CODE   = 3'h4;
	localparam logic [1:0] PAT_CODE_9     = 2'h0;
	localparam logic [1:0] PAT_CODE_31    = 2'h2;
	localparam logic [2:0] MUX_RAW        = 3'h0;
	localparam logic [2:0] MUX_RETIMED    = 3'h1;
	localparam logic [2:0] MUX_PATTERN    = 3'h4;
	localparam logic [2:0] MUX_MUTE       = 3'h7;
	localparam logic [7:0] SEED_ALL_ONES  = 8'hff;
	localparam logic [4:0] CAP_START      = 5'h08;
	localparam logic [4:0] DAC_START      = 5'h12;

endpackage

// >>> include/vop_if.sv
// Interface: configuration port between controller and channel
interface vop_if;
	logic       wr_en;
	logic       rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport channel (input wr_en, input rd_en, input addr, input wdata, output rdata);
	modport ctrl    (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface

// >>> rtl/vop_channel.sv
// Channel end: override registers, divider choice, pattern generator and output select
module vop_channel (
	input  wire logic         core_clk_in,
	input  wire logic         reset_in,
	vop_if.channel            cfg,
	input  wire logic [2:0]   auto_div_code_in,
	input  wire logic [4:0]   auto_cap_count_in,
	input  wire logic         signal_present_in,
	input  wire logic         cdr_locked_in,
	input  wire logic         raw_data_in,
	input  wire logic         retimed_data_in,
	output logic [2:0]        vco_div_code_out,
	output logic [4:0]        vco_cap_count_out,
	output logic [4:0]        loop_filter_voltage_source_out,
	output logic              loop_dac_enable_out,
	output logic              charge_pump_enable_out,
	output logic              channel_enable_out,
	output logic              serial_out,
	output logic              pattern_bit_out
);
	import vop_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0]  cap;
		logic [7:0]  ovr;
		logic [7:0]  pclk;
		logic [7:0]  sd;
		logic [7:0]  div;
		logic [7:0]  cp;
		logic [7:0]  osel;
		logic [7:0]  dac;
		logic [7:0]  pcfg;
		logic [7:0]  rdata;
		logic [30:0] lfsr;
		logic        sig_m;
		logic        sig_s;
		logic        lock_m;
		logic        lock_s;
		logic        raw_m;
		logic        raw_s;
		logic        ret_m;
		logic        ret_s;
		logic [2:0]  div_o;
		logic [4:0]  cap_o;
		logic [4:0]  dac_o;
		logic        dac_en_o;
		logic        cp_en_o;
		logic        ch_en_o;
		logic        ser_o;
		logic        pat_o;
	} vop_ch_state_t;

	vop_ch_state_t st_q;
	vop_ch_state_t st_d;
	logic          fb;
	logic [2:0]    mux;
	logic          ch_en;

	always_comb begin
		st_d = st_q;
		fb = 1'b0;
		mux = MUX_MUTE;
		ch_en = 1'b0;
		// Two-stage synchronisers on the signal, lock, raw and retimed inputs; divider and cap inputs are not synchronised
		st_d.sig_m  = signal_present_in;
		st_d.sig_s  = st_q.sig_m;
		st_d.lock_m = cdr_locked_in;
		st_d.lock_s = st_q.lock_m;
		st_d.raw_m  = raw_data_in;
		st_d.raw_s  = st_q.raw_m;
		st_d.ret_m  = retimed_data_in;
		st_d.ret_s  = st_q.ret_m;

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		// Whole byte per write
		if (cfg.wr_en) begin
			unique case (cfg.addr)
				REG_CAP_COUNT:   st_d.cap = cfg.wdata;
				REG_OVERRIDE:    st_d.ovr = cfg.wdata;
				REG_PAT_CLK_EN:  st_d.pclk = cfg.wdata;
				REG_SIG_DETECT:  st_d.sd = cfg.wdata;
				REG_DIV_SELECT:  st_d.div = cfg.wdata;
				REG_CHARGE_PUMP: st_d.cp = cfg.wdata;
				REG_OUT_SELECT:  st_d.osel = cfg.wdata;
				REG_LOOP_DAC:    st_d.dac = cfg.wdata;
				REG_PAT_CONFIG:  st_d.pcfg = cfg.wdata;
				default:         st_d.cap = st_q.cap;
			endcase
		end
		// Override bits read back as written
		st_d.rdata = 8'h00;
		if (cfg.rd_en) begin
			unique case (cfg.addr)
				REG_CAP_COUNT:   st_d.rdata = st_q.cap;
				REG_OVERRIDE:    st_d.rdata = st_q.ovr;
				REG_PAT_CLK_EN:  st_d.rdata = st_q.pclk;
				REG_SIG_DETECT:  st_d.rdata = st_q.sd;
				REG_DIV_SELECT:  st_d.rdata = st_q.div;
				REG_CHARGE_PUMP: st_d.rdata = st_q.cp;
				REG_OUT_SELECT:  st_d.rdata = st_q.osel;
				REG_LOOP_DAC:    st_d.rdata = st_q.dac;
				REG_PAT_CONFIG:  st_d.rdata = st_q.pcfg;
				default:         st_d.rdata = 8'h00;
			endcase
		end

		// ----------------------------------------
		// Loop and VCO controls
		// ----------------------------------------
		// Automatic divider choice
		st_d.div_o = (auto_div_code_in > DIV_MAX_CODE) ? DIV_MAX_CODE : auto_div_code_in;
		if (st_q.ovr[OVR_DIV_BIT]) begin
			// Codes above four clamp to four
			st_d.div_o = (st_q.div[DIV_LSB +: 3] > DIV_MAX_CODE) ? DIV_MAX_CODE
				: st_q.div[DIV_LSB +: 3];
		end
		st_d.cap_o = st_q.ovr[OVR_CAP_BIT] ? st_q.cap[4:0] : auto_cap_count_in;
		st_d.dac_en_o = st_q.ovr[OVR_LOOP_DAC_BIT];
		st_d.dac_o = st_q.dac[4:0];
		st_d.cp_en_o = !(st_q.ovr[OVR_CP_BIT] && st_q.cp[1:0] == 2'h0);

		// ----------------------------------------
		// Channel enable and output select
		// ----------------------------------------
		// Off without signal; forced on, but force-off wins when both bits are set
		ch_en = st_q.sd[SD_FORCE_ON_BIT] && !st_q.sd[SD_FORCE_OFF_BIT] ? 1'b1
			: (st_q.sd[SD_FORCE_OFF_BIT] ? 1'b0 : st_q.sig_s);
		st_d.ch_en_o = ch_en;
		if (st_q.ovr[OVR_MUX_BIT])
			mux = st_q.osel[MUX_LSB +: 3];
		else if (st_q.lock_s)
			mux = MUX_RETIMED;
		else
			mux = st_q.osel[MUX_LSB +: 3];
		st_d.ser_o = 1'b0;
		if (ch_en) begin
			unique case (mux)
				MUX_RAW:     st_d.ser_o = st_q.raw_s;
				MUX_RETIMED: st_d.ser_o = st_q.ret_s;
				MUX_PATTERN: st_d.ser_o = st_q.pat_o;
				default:     st_d.ser_o = 1'b0;
			endcase
		end

		// ----------------------------------------
		// Pattern generator
		// ----------------------------------------
		// Pattern length feedback
		fb = (st_q.pcfg[1:0] == PAT_CODE_31) ? (st_q.lfsr[30] ^ st_q.lfsr[27])
			: (st_q.lfsr[8] ^ st_q.lfsr[4]);
		if (!st_q.osel[PAT_EN_BIT] || !st_q.pcfg[PAT_LOAD_BIT]) begin
			st_d.lfsr = {23'h7fffff, SEED_ALL_ONES};
		end else if (st_q.pclk[PAT_CLK_EN_BIT]) begin
			st_d.lfsr = {st_q.lfsr[29:0], fb};
		end
		st_d.pat_o = st_q.osel[PAT_EN_BIT] && st_q.pcfg[PAT_LOAD_BIT]
			&& st_q.pclk[PAT_CLK_EN_BIT] ? fb : 1'b0;
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			st_q <= '0;
			st_q.ovr <= OVR_RESET;
			st_q.osel <= OUT_SEL_RESET;
			st_q.cp <= CP_RESET;
			st_q.cp_en_o <= 1'b1;
			st_q.lfsr <= {23'h7fffff, SEED_ALL_ONES};
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg.rdata = st_q.rdata;
	assign vco_div_code_out = st_q.div_o;
	assign vco_cap_count_out = st_q.cap_o;
	assign loop_filter_voltage_source_out = st_q.dac_o;
	assign loop_dac_enable_out = st_q.dac_en_o;
	assign charge_pump_enable_out = st_q.cp_en_o;
	assign channel_enable_out = st_q.ch_en_o;
	assign serial_out = st_q.ser_o;
	assign pattern_bit_out = st_q.pat_o;
endmodule

// >>> rtl/vop_controller.sv
// Controller end: runs the free-run pattern sequence and passes plain register access
module vop_controller (
	input  wire logic         core_clk_in,
	input  wire logic         reset_in,
	vop_if.ctrl               cfg,
	input  wire logic [7:0]   sw_addr_in,
	input  wire logic [7:0]   sw_wdata_in,
	input  wire logic         sw_wr_in,
	input  wire logic         sw_rd_in,
	output logic [7:0]        sw_rdata_out
);
	import vop_pkg::*;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [4:0] {
		S_IDLE  = 5'h00, S_SD    = 5'h01, S_OVR_CP = 5'h03, S_CP    = 5'h02,
		S_RD1   = 5'h06, S_OVR_D = 5'h07, S_DIV    = 5'h05, S_RD2   = 5'h04,
		S_OVR_C = 5'h0c, S_CAP   = 5'h0d, S_RD3    = 5'h0f, S_OVR_L = 5'h0e,
		S_DAC   = 5'h0a, S_PEN   = 5'h0b, S_PRST   = 5'h09, S_PSEL  = 5'h08,
		S_PLOAD = 5'h18, S_PCLK  = 5'h19, S_RD4    = 5'h1b, S_OVR_M = 5'h1a,
		S_MUX   = 5'h1e
	} vop_seq_t;

	typedef struct packed {
		vop_seq_t    seq;
		logic [7:0]  ovr_img;
		logic [2:0]  rate;
		logic        pat31;
		logic        busy;
		logic        rd_dev;
		logic        rd_loc;
		logic [7:0]  loc_data;
		logic        rd_dev2;
		logic        rd_loc2;
		logic [7:0]  loc_data2;
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [7:0]  wdata;
		logic [7:0]  sw_rdata;
	} vop_ctl_state_t;

	vop_ctl_state_t st_q;
	vop_ctl_state_t st_d;

	task automatic put(input logic [7:0] a, input logic [7:0] d);
		st_d.wr = 1'b1;
		st_d.addr = a;
		st_d.wdata = d;
	endtask

	always_comb begin
		st_d = st_q;
		st_d.wr = 1'b0;
		st_d.rd = 1'b0;
		st_d.rd_dev = 1'b0;
		st_d.rd_loc = 1'b0;
		// Second read stage lines local data up with the channel answer
		st_d.rd_dev2 = st_q.rd_dev;
		st_d.rd_loc2 = st_q.rd_loc;
		st_d.loc_data2 = st_q.loc_data;
		st_d.sw_rdata = st_q.rd_dev2 ? cfg.rdata : (st_q.rd_loc2 ? st_q.loc_data2 : 8'h00);
		// ----------------------------------------
		// Software port
		// ----------------------------------------
		if (sw_wr_in && sw_addr_in == CMD_RATE && !st_q.busy) begin
			st_d.rate = (sw_wdata_in[2:0] > DIV_MAX_CODE) ? DIV_MAX_CODE : sw_wdata_in[2:0];
			st_d.pat31 = sw_wdata_in[7];
			st_d.busy = sw_wdata_in[6];
			st_d.seq = sw_wdata_in[6] ? S_SD : S_IDLE;
		end else if (sw_wr_in && sw_addr_in == CMD_STATUS && !st_q.busy) begin
			put(REG_OVERRIDE, OVR_RESET);
			st_d.ovr_img = OVR_RESET;
		end else if (sw_wr_in && !st_q.busy && sw_addr_in < CMD_RATE) begin
			put(sw_addr_in, sw_wdata_in);
		end
		if (sw_rd_in) begin
			st_d.loc_data = (sw_addr_in == CMD_STATUS) ? {7'h00, st_q.busy}
				: (sw_addr_in == CMD_RATE) ? {st_q.pat31, st_q.busy, 3'h0, st_q.rate}
				: st_q.ovr_img;
			st_d.rd_loc = (sw_addr_in >= CMD_RATE) || st_q.busy;
			if (sw_addr_in < CMD_RATE && !st_q.busy) begin
				st_d.rd = 1'b1;
				st_d.addr = sw_addr_in;
				st_d.rd_dev = 1'b1;
			end
		end
		// ----------------------------------------
		// Free-run pattern sequence
		// ----------------------------------------
		// Override image keeps earlier bits
		if (st_q.busy) begin
			unique case (st_q.seq)
				S_SD:    begin put(REG_SIG_DETECT, 8'h80); st_d.seq = S_OVR_CP; end
				S_OVR_CP: begin
					st_d.ovr_img[OVR_CP_BIT] = 1'b1;
					put(REG_OVERRIDE, st_d.ovr_img);
					st_d.seq = S_CP;
				end
				S_CP:    begin put(REG_CHARGE_PUMP, 8'h00); st_d.seq = S_RD1; end
				S_RD1:   st_d.seq = S_OVR_D;
				S_OVR_D: begin
					st_d.ovr_img[OVR_DIV_BIT] = 1'b1;
					put(REG_OVERRIDE, st_d.ovr_img);
					st_d.seq = S_DIV;
				end
				S_DIV:   begin put(REG_DIV_SELECT, {1'b0, st_q.rate, 4'h0}); st_d.seq = S_RD2; end
				S_RD2:   st_d.seq = S_OVR_C;
				S_OVR_C: begin
					st_d.ovr_img[OVR_CAP_BIT] = 1'b1;
					put(REG_OVERRIDE, st_d.ovr_img);
					st_d.seq = S_CAP;
				end
				S_CAP:   begin put(REG_CAP_COUNT, {3'h0, CAP_START}); st_d.seq = S_RD3; end
				S_RD3:   st_d.seq = S_OVR_L;
				S_OVR_L: begin
					st_d.ovr_img[OVR_LOOP_DAC_BIT] = 1'b1;
					put(REG_OVERRIDE, st_d.ovr_img);
					st_d.seq = S_DAC;
				end
				S_DAC:   begin put(REG_LOOP_DAC, {3'h0, DAC_START}); st_d.seq = S_PEN; end
				S_PEN:   begin put(REG_OUT_SELECT, 8'hf0); st_d.seq = S_PRST; end
				S_PRST:  begin put(REG_PAT_CONFIG, 8'h00); st_d.seq = S_PSEL; end
				S_PSEL:  begin
					put(REG_PAT_CONFIG, {6'h00, st_q.pat31 ? PAT_CODE_31 : PAT_CODE_9});
					st_d.seq = S_PLOAD;
				end
				S_PLOAD: begin
					put(REG_PAT_CONFIG, {5'h01, 1'b0, st_q.pat31 ? PAT_CODE_31 : PAT_CODE_9});
					st_d.seq = S_PCLK;
				end
				S_PCLK:  begin put(REG_PAT_CLK_EN, 8'h20); st_d.seq = S_RD4; end
				S_RD4:   st_d.seq = S_OVR_M;
				S_OVR_M: begin
					st_d.ovr_img[OVR_MUX_BIT] = 1'b1;
					st_d.ovr_img[OVR_QCLK_BIT] = 1'b1;
					put(REG_OVERRIDE, st_d.ovr_img);
					st_d.seq = S_MUX;
				end
				S_MUX:   begin
					put(REG_OUT_SELECT, {MUX_PATTERN, 5'h10});
					st_d.seq = S_IDLE;
					st_d.busy = 1'b0;
				end
				default: begin st_d.seq = S_IDLE; st_d.busy = 1'b0; end
			endcase
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			st_q <= '0;
			st_q.seq <= S_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign cfg.wr_en = st_q.wr;
	assign cfg.rd_en = st_q.rd;
	assign cfg.addr = st_q.addr;
	assign cfg.wdata = st_q.wdata;
	assign sw_rdata_out = st_q.sw_rdata;
endmodule

// >>> verif/vop_assertions.sv
// Checker: configuration port between controller and channel
module vop_assertions
	import vop_pkg::*;
(
	input  wire logic       core_clk_in,
	input  wire logic       reset_in,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic [7:0] rdata
);
	logic [7:0] mem_q [256];
	logic [7:0] exp_q;
	logic       hit;

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);

	// ----------------------------------------
	// Shadow of the channel registers
	// ----------------------------------------
	assign hit = addr inside {REG_CAP_COUNT, REG_OVERRIDE, REG_PAT_CLK_EN, REG_SIG_DETECT,
		REG_DIV_SELECT, REG_CHARGE_PUMP, REG_OUT_SELECT, REG_LOOP_DAC, REG_PAT_CONFIG};

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			foreach (mem_q[i]) begin
				mem_q[i] <= REG_RESET;
			end
			mem_q[REG_OUT_SELECT] <= OUT_SEL_RESET;
			mem_q[REG_CHARGE_PUMP] <= CP_RESET;
		end else if (wr_en && hit) begin
			mem_q[addr] <= wdata;
		end
		exp_q <= hit ? mem_q[addr] : 8'h00;
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	strobe_exclusive_a: assert property (!(wr_en && rd_en))
		else $error("write and read strobe together");
	read_answer_a: assert property (rd_en |=> rdata == exp_q)
		else $error("read data differs from register image");
	rdata_idle_a: assert property (!rd_en |=> rdata == 8'h00)
		else $error("read data not zero outside answer cycle");
	unmapped_zero_a: assert property (rd_en && !hit |=> rdata == 8'h00)
		else $error("unmapped read not zero");
	div_code_valid_a: assert property (wr_en && addr == REG_DIV_SELECT
		|-> wdata[6:4] <= DIV_MAX_CODE)
		else $error("invalid divider code written");
	div_freerun_a: assert property (wr_en && addr == REG_OVERRIDE && wdata[OVR_DIV_BIT]
		|-> wdata[OVR_CP_BIT] && mem_q[REG_CHARGE_PUMP][1:0] == 2'h0)
		else $error("divider override without free-run");
	ovr_keep_a: assert property (wr_en && addr == REG_OVERRIDE && wdata != OVR_RESET
		|-> (wdata & mem_q[REG_OVERRIDE]) == mem_q[REG_OVERRIDE])
		else $error("earlier override bit dropped");
	clk_en_order_a: assert property (wr_en && addr == REG_PAT_CLK_EN
		&& wdata[PAT_CLK_EN_BIT]
		|-> mem_q[REG_PAT_CONFIG][PAT_LOAD_BIT] && mem_q[REG_OUT_SELECT][PAT_EN_BIT])
		else $error("pattern clock enabled out of order");

	cover property (wr_en && addr == REG_OVERRIDE && wdata == 8'hfc);
	cover property (wr_en && addr == REG_OVERRIDE && wdata == OVR_RESET);
	cover property (rd_en && !hit);
endmodule

// >>> verif/tb_vop_override_prbs_control.sv
// Testbench: controller and channel joined, driven from the software port
module tb_vop_override_prbs_control;
	timeunit 1ns;
	timeprecision 1ps;
	import vop_pkg::*;
	logic       core_clk_in = 1'b0;
	logic       reset_in    = 1'b1;
	logic [7:0] sw_addr     = 8'h00;
	logic [7:0] sw_wdata    = 8'h00;
	logic [7:0] sw_rdata;
	logic       sw_wr       = 1'b0;
	logic       sw_rd       = 1'b0;
	logic [2:0] auto_div    = 3'h0;
	logic [4:0] auto_cap    = 5'h00;
	logic       sig         = 1'b0;
	logic       lock        = 1'b0;
	logic       raw         = 1'b0;
	logic       ret         = 1'b0;
	logic [2:0] div_code;
	logic [4:0] cap, dac;
	logic       dac_en, cp_en, ch_en, ser, pat;
	int         failures    = 0;
	int         num_checks  = 0;
	int         cycles      = 0;
	logic [7:0] mdl [256];
	logic [7:0] regs [9] = '{REG_CAP_COUNT, REG_OVERRIDE, REG_PAT_CLK_EN, REG_SIG_DETECT,
		REG_DIV_SELECT, REG_CHARGE_PUMP, REG_OUT_SELECT, REG_LOOP_DAC, REG_PAT_CONFIG};

	vop_if cfg_if ();
	vop_controller i_vop_controller (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.cfg(cfg_if), .sw_addr_in(sw_addr), .sw_wdata_in(sw_wdata), .sw_wr_in(sw_wr),
		.sw_rd_in(sw_rd), .sw_rdata_out(sw_rdata));
	vop_channel i_vop_channel (.core_clk_in(core_clk_in), .reset_in(reset_in), .cfg(cfg_if),
		.auto_div_code_in(auto_div), .auto_cap_count_in(auto_cap), .signal_present_in(sig),
		.cdr_locked_in(lock), .raw_data_in(raw), .retimed_data_in(ret),
		.vco_div_code_out(div_code), .vco_cap_count_out(cap),
		.loop_filter_voltage_source_out(dac), .loop_dac_enable_out(dac_en),
		.charge_pump_enable_out(cp_en), .channel_enable_out(ch_en), .serial_out(ser),
		.pattern_bit_out(pat));
	vop_assertions i_vop_assertions (.core_clk_in(core_clk_in), .reset_in(reset_in),
		.wr_en(cfg_if.wr_en), .rd_en(cfg_if.rd_en), .addr(cfg_if.addr),
		.wdata(cfg_if.wdata), .rdata(cfg_if.rdata));

	always #5 core_clk_in = ~core_clk_in;

	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			report_and_stop();
		end
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reset_mdl();
		foreach (mdl[i]) begin
			mdl[i] = REG_RESET;
		end
		mdl[REG_OUT_SELECT] = OUT_SEL_RESET;
		mdl[REG_CHARGE_PUMP] = CP_RESET;
	endtask

	task automatic sw_wr_t(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		sw_addr <= a;
		sw_wdata <= d;
		sw_wr <= 1'b1;
		@(posedge core_clk_in);
		sw_wr <= 1'b0;
		if (a < 8'h40) mdl[a] = d;
		repeat (2) @(posedge core_clk_in);
	endtask

	task automatic sw_rd_t(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		sw_addr <= a;
		sw_rd <= 1'b1;
		@(posedge core_clk_in);
		sw_rd <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		#1 d = sw_rdata;
	endtask

	task automatic rd(input logic [7:0] a);
		logic [7:0] d;
		sw_rd_t(a, d);
		chk(d, mdl[a]);
	endtask

	task automatic settle();
		repeat (6) @(posedge core_clk_in);
		#1;
	endtask

	task automatic watch(input int n, input bit cmp, input bit p31, output int t);
		logic p0;
		logic q[$];
		int   lag;
		t = 0;
		lag = p31 ? 31 : 9;
		@(posedge core_clk_in);
		#1 p0 = pat;
		q.push_back(pat);
		repeat (n) begin
			@(posedge core_clk_in);
			#1;
			if (cmp) chk({7'h0, ser}, {7'h0, p0});
			// Each bit, once lag earlier bits are held, against the recurrence of the selected sequence
			if (cmp && q.size() >= lag) chk({7'h0, pat},
				{7'h0, q[q.size() - lag] ^ q[q.size() - lag + (p31 ? 3 : 4)]});
			if (pat !== p0) t++;
			p0 = pat;
			q.push_back(pat);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [7:0] d;
		int         t;
		int         code;
		void'($urandom(19));
		reset_mdl();
		repeat (5) @(posedge core_clk_in);
		reset_in <= 1'b0;
		foreach (regs[i]) rd(regs[i]);
		rd(8'h05);
		settle();
		chk({7'h0, ch_en}, 8'h00);
		chk({7'h0, ser}, 8'h00);
		@(posedge core_clk_in);
		auto_div <= 3'($urandom_range(4));
		auto_cap <= 5'($urandom);
		settle();
		chk({5'h0, div_code}, {5'h0, auto_div});
		chk({3'h0, cap}, {3'h0, auto_cap});
		sw_wr_t(REG_OVERRIDE, 8'h08);
		sw_wr_t(REG_CHARGE_PUMP, 8'h00);
		settle();
		chk({7'h0, cp_en}, 8'h00);
		sw_wr_t(REG_OVERRIDE, 8'h0c);
		for (int c = 0; c < 5; c++) begin
			sw_wr_t(REG_DIV_SELECT, (8'($urandom) & 8'h8f) | 8'(c << 4));
			settle();
			chk({5'h0, div_code}, 8'(c));
			rd(REG_DIV_SELECT);
		end
		sw_wr_t(REG_OVERRIDE, 8'h8c);
		sw_wr_t(REG_CAP_COUNT, 8'he8);
		sw_wr_t(REG_OVERRIDE, 8'hcc);
		sw_wr_t(REG_LOOP_DAC, 8'h12);
		settle();
		chk({3'h0, cap}, {3'h0, CAP_START});
		chk({3'h0, dac}, {3'h0, DAC_START});
		chk({7'h0, dac_en}, 8'h01);
		rd(REG_OVERRIDE);
		@(posedge core_clk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		reset_in <= 1'b0;
		reset_mdl();
		rd(REG_OVERRIDE);
		@(posedge core_clk_in);
		sig <= 1'b1;
		sw_wr_t(REG_OVERRIDE, 8'h20);
		sw_wr_t(REG_OUT_SELECT, {MUX_RAW, 5'h00});
		for (int b = 0; b < 2; b++) begin
			raw <= 1'(b);
			lock <= 1'(b);
			settle();
			chk({7'h0, ser}, 8'(b));
		end
		sw_wr_t(REG_OUT_SELECT, {MUX_MUTE, 5'h00});
		settle();
		chk({7'h0, ser}, 8'h00);
		sw_wr_t(REG_OVERRIDE, 8'h00);
		lock <= 1'b1;
		ret <= 1'b1;
		settle();
		chk({7'h0, ser}, 8'h01);
		@(posedge core_clk_in);
		sig <= 1'b0;
		lock <= 1'b0;
		for (int p = 0; p < 2; p++) begin
			code = $urandom_range(4);
			sw_wr_t(CMD_RATE, {1'(p), 1'b1, 3'h0, 3'(code)});
			for (int k = 0; k < 20; k++) begin
				sw_rd_t(CMD_STATUS, d);
				if (d[0] == 1'b0) break;
			end
			chk(d & 8'h01, 8'h00);
			mdl[REG_OVERRIDE] = 8'hfc;
			mdl[REG_PAT_CONFIG] = p ? 8'h0a : 8'h08;
			mdl[REG_OUT_SELECT] = 8'h90;
			rd(REG_OVERRIDE);
			rd(REG_PAT_CONFIG);
			rd(REG_OUT_SELECT);
			settle();
			chk({7'h0, ch_en}, 8'h01);
			chk({5'h0, div_code}, 8'(code));
			chk({3'h0, cap}, {3'h0, CAP_START});
			chk({3'h0, dac}, {3'h0, DAC_START});
			chk({7'h0, cp_en}, 8'h00);
			watch(60, 1'b1, 1'(p), t);
			chk(8'(t > 0), 8'h01);
			sw_wr_t(REG_PAT_CLK_EN, 8'h00);
			settle();
			watch(20, 1'b0, 1'b0, t);
			chk(8'(t), 8'h00);
			sw_wr_t(REG_PAT_CLK_EN, 8'h20);
			sw_wr_t(REG_OUT_SELECT, {MUX_PATTERN, 5'h00});
			settle();
			watch(20, 1'b0, 1'b0, t);
			chk({7'h0, pat}, 8'h00);
			chk(8'(t), 8'h00);
			sw_wr_t(REG_OUT_SELECT, {MUX_PATTERN, 5'h10});
			sw_wr_t(REG_PAT_CONFIG, p ? 8'h02 : 8'h00);
			settle();
			watch(20, 1'b0, 1'b0, t);
			chk({7'h0, pat}, 8'h00);
			chk(8'(t), 8'h00);
			sw_wr_t(CMD_STATUS, 8'h00);
			mdl[REG_OVERRIDE] = OVR_RESET;
			rd(REG_OVERRIDE);
		end
		report_and_stop();
	end
endmodule
